// ### pkg/pic_map.svh
// Register offsets and reset values of the parallel I/O controller.
// Assumes byte addresses on an 8-bit register port, one word a register.
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

`define PIC_OWN_EN_OFF    8'h00
`define PIC_OWN_DIS_OFF   8'h04
`define PIC_OWN_STAT_OFF  8'h08
`define PIC_DIR_EN_OFF    8'h10
`define PIC_DIR_DIS_OFF   8'h14
`define PIC_DIR_STAT_OFF  8'h18
`define PIC_FLT_EN_OFF    8'h20
`define PIC_FLT_DIS_OFF   8'h24
`define PIC_FLT_STAT_OFF  8'h28
`define PIC_OUT_SET_OFF   8'h30
`define PIC_OUT_CLR_OFF   8'h34
`define PIC_OUT_STAT_OFF  8'h38
`define PIC_PIN_LVL_OFF   8'h3c
`define PIC_IRQ_EN_OFF    8'h40
`define PIC_IRQ_DIS_OFF   8'h44
`define PIC_IRQ_MASK_OFF  8'h48
`define PIC_CHG_STAT_OFF  8'h4c
`define PIC_OD_EN_OFF     8'h50
`define PIC_OD_DIS_OFF    8'h54
`define PIC_OD_STAT_OFF   8'h58

// Lines present and lines shared with a peripheral, per controller
`define PIC_LINES_A       32'h3fffffff
`define PIC_SHARED_A      32'h3fffffff
`define PIC_LINES_B       32'h0fffffff
`define PIC_SHARED_B      32'h0ffc00f8
`define PIC_ZERO_RST      32'h00000000

`endif

// ### pkg/pic_pkg.sv
// Types of the parallel I/O controller.
// Assumes pic_map.svh supplies all numeric constants.
package pic_pkg;

  typedef logic [31:0] pic_word_t;

  typedef struct packed {
    pic_word_t own;
    pic_word_t dir;
    pic_word_t odsr;
    pic_word_t filt;
    pic_word_t imr;
    pic_word_t isr;
    pic_word_t md;
    pic_word_t sync1;
    pic_word_t sync2;
    pic_word_t sync3;
    pic_word_t lvl;
    pic_word_t rdata;
    pic_word_t per_in;
    pic_word_t pin_out;
    pic_word_t pin_oe;
    logic      irq;
  } pic_state_t;

endpackage : pic_pkg

// ### design/pic_ctrl.sv
// Parallel I/O controller: one port of up to 32 lines with pin muxing,
// direction, output data, glitch filter, open drain and change status.
// Assumes a synchronous register port on CLK and asynchronous pin inputs.
// Overview of operation
// - After reset every line is owned by I/O logic and is an input
// - Ownership set by enable/disable writes, shown in ownership status
// - Dedicated lines ignore ownership writes and always read owned
// - Peripheral input forced to zero while I/O logic owns the line
// - Direction set by enable/disable writes; acts only on owned lines
// - Owned outputs driven from set/clear data, readable in data status
// - Owned inputs are undriven; unowned lines follow the peripheral
// - Pin level register shows the real level on every line
// - Per-line glitch filter, switchable, used in both modes, readable
// - Interrupt enable/disable writes set/clear mask bits
// - Any level change sets the line's change status bit
// - Interrupt output high while a masked-in change bit is set
// - Reading change status returns it and then clears it
// - 32-bit registers; undefined lines ignore writes and read zero
// - Open-drain lines drive only low, release instead of high
// - Open drain set by enable/disable writes, in both modes, readable
// - Two instances serve 58 lines, 13 dedicated, rest shared
// - First controller bits 0 to 3 carry the timer 3/4 signals
// - Direction writes stored even while a peripheral owns the line
`timescale 1ns/1ps
`include "pic_map.svh"

module pic_ctrl
  import pic_pkg::*;
#(
  // Instance B: LINE_MASK `PIC_LINES_B, SHARED_MASK `PIC_SHARED_B
  // Two instances cover all lines; masks pick dedicated and shared lines
  parameter logic [31:0] LINE_MASK   = `PIC_LINES_A,
  parameter logic [31:0] SHARED_MASK = `PIC_SHARED_A
) (
  // Clock and reset
  input  wire  logic        CLK,
  input  wire  logic        RSTN,
  // Register port
  input  wire  logic [7:0]  ADDR,
  input  wire  logic [31:0] WDATA,
  input  wire  logic        WR,
  input  wire  logic        RD,
  output logic       [31:0] RDATA,
  // Pins
  input  wire  logic [31:0] PIN_IN,
  output logic       [31:0] PIN_OUT,
  output logic       [31:0] PIN_OE,
  // Peripheral side
  input  wire  logic [31:0] PER_OUT,
  input  wire  logic [31:0] PER_OE,
  output logic       [31:0] PER_IN,
  // Interrupt
  output logic              IRQ
);

  pic_state_t  st_q;
  pic_state_t  st_d;
  logic [31:0] wv;
  logic [31:0] stable;
  logic [31:0] chg;
  logic [31:0] src_out;
  logic [31:0] src_oe;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  always_comb begin
    st_d = st_q;
    wv   = WDATA & LINE_MASK;
    if (WR) begin
      if (hit(ADDR, `PIC_OWN_EN_OFF)) begin
        st_d.own = st_q.own | wv;
      end else if (hit(ADDR, `PIC_OWN_DIS_OFF)) begin
        st_d.own = st_q.own & ~(wv & SHARED_MASK);
      end else if (hit(ADDR, `PIC_DIR_EN_OFF)) begin
        st_d.dir = st_q.dir | wv;
      end else if (hit(ADDR, `PIC_DIR_DIS_OFF)) begin
        st_d.dir = st_q.dir & ~wv;
      end else if (hit(ADDR, `PIC_FLT_EN_OFF)) begin
        st_d.filt = st_q.filt | wv;
      end else if (hit(ADDR, `PIC_FLT_DIS_OFF)) begin
        st_d.filt = st_q.filt & ~wv;
      end else if (hit(ADDR, `PIC_OUT_SET_OFF)) begin
        st_d.odsr = st_q.odsr | wv;
      end else if (hit(ADDR, `PIC_OUT_CLR_OFF)) begin
        st_d.odsr = st_q.odsr & ~wv;
      end else if (hit(ADDR, `PIC_IRQ_EN_OFF)) begin
        st_d.imr = st_q.imr | wv;
      end else if (hit(ADDR, `PIC_IRQ_DIS_OFF)) begin
        st_d.imr = st_q.imr & ~wv;
      end else if (hit(ADDR, `PIC_OD_EN_OFF)) begin
        st_d.md = st_q.md | wv;
      end else if (hit(ADDR, `PIC_OD_DIS_OFF)) begin
        st_d.md = st_q.md & ~wv;
      end
    end

    // Two-stage synchroniser, then a third stage for the filter
    // Raw pin goes straight into the first flop; masking waits until
    // after the second stage so no gate sits ahead of the synchroniser
    st_d.sync1 = PIN_IN;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    // Filter passes a level only once it held for two samples
    stable   = ~(st_q.sync2 ^ st_q.sync3);
    st_d.lvl = ((st_q.sync2 & (~st_q.filt | stable))
             | (st_q.lvl & st_q.filt & ~stable)) & LINE_MASK;
    chg      = st_d.lvl ^ st_q.lvl;

    // A change in the cycle of the clearing read is kept
    if (RD && hit(ADDR, `PIC_CHG_STAT_OFF)) begin
      st_d.isr = chg;
    end else begin
      st_d.isr = st_q.isr | chg;
    end

    st_d.rdata = `PIC_ZERO_RST;
    if (RD) begin
      if (hit(ADDR, `PIC_OWN_STAT_OFF)) begin
        st_d.rdata = st_q.own;
      end else if (hit(ADDR, `PIC_DIR_STAT_OFF)) begin
        st_d.rdata = st_q.dir;
      end else if (hit(ADDR, `PIC_FLT_STAT_OFF)) begin
        st_d.rdata = st_q.filt;
      end else if (hit(ADDR, `PIC_OUT_STAT_OFF)) begin
        st_d.rdata = st_q.odsr;
      end else if (hit(ADDR, `PIC_PIN_LVL_OFF)) begin
        st_d.rdata = st_q.lvl;
      end else if (hit(ADDR, `PIC_IRQ_MASK_OFF)) begin
        st_d.rdata = st_q.imr;
      end else if (hit(ADDR, `PIC_CHG_STAT_OFF)) begin
        st_d.rdata = st_q.isr;
      end else if (hit(ADDR, `PIC_OD_STAT_OFF)) begin
        st_d.rdata = st_q.md;
      end
    end

    // Pin driver: owner selects source, open drain never drives high
    src_out = (st_q.own & st_q.odsr) | (~st_q.own & PER_OUT);
    src_oe  = (st_q.own & st_q.dir) | (~st_q.own & PER_OE);
    st_d.pin_oe  = src_oe & ~(st_q.md & src_out) & LINE_MASK;
    st_d.pin_out = src_out & ~st_q.md & LINE_MASK;
    st_d.per_in  = st_q.lvl & ~st_q.own & LINE_MASK;
    st_d.irq     = |(st_d.isr & st_d.imr);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q         <= '0;
      st_q.own     <= LINE_MASK;
      st_q.dir     <= `PIC_ZERO_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign RDATA   = st_q.rdata;
  assign PIN_OUT = st_q.pin_out;
  assign PIN_OE  = st_q.pin_oe;
  assign PER_IN  = st_q.per_in;
  assign IRQ     = st_q.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_chg_read;
    RD && hit(ADDR, `PIC_CHG_STAT_OFF);
  endsequence

  sequence s_own_write;
    WR && hit(ADDR, `PIC_OWN_EN_OFF);
  endsequence

  a_dedicated_owned: assert property (
    (st_q.own & LINE_MASK & ~SHARED_MASK) == (LINE_MASK & ~SHARED_MASK))
    else $error("dedicated line lost ownership");

  a_per_in_zero: assert property (
    1'b1 |=> ((PER_IN & $past(st_q.own)) == 32'h00000000))
    else $error("peripheral input not zero on owned line");

  a_own_set: assert property (
    s_own_write |=> ((st_q.own & $past(wv)) == $past(wv)))
    else $error("ownership enable write not taken");

  a_dir_store: assert property (
    WR && hit(ADDR, `PIC_DIR_EN_OFF) |=>
      ((st_q.dir & $past(wv)) == $past(wv)))
    else $error("direction not stored");

  a_out_clear: assert property (
    WR && hit(ADDR, `PIC_OUT_CLR_OFF) |=>
      ((st_q.odsr & $past(wv)) == 32'h00000000))
    else $error("output data not cleared");

  a_od_no_high: assert property (
    1'b1 |=> ((PIN_OE & PIN_OUT & $past(st_q.md)) == 32'h00000000))
    else $error("open-drain line driven high");

  a_chg_clear_read: assert property (
    s_chg_read |=> (st_q.isr == $past(chg)) &&
      (RDATA == $past(st_q.isr)))
    else $error("change status read did not clear");

  a_chg_sets: assert property (
    1'b1 |=> ((st_q.isr & $past(chg)) == $past(chg)))
    else $error("level change not recorded");

  a_irq_level: assert property (
    ((st_q.isr & st_q.imr) != 32'h00000000) |-> IRQ)
    else $error("interrupt not asserted");

  a_dir_clear: assert property (
    WR && hit(ADDR, `PIC_DIR_DIS_OFF) |=>
      ((st_q.dir & $past(wv)) == 32'h00000000))
    else $error("direction not cleared");

  a_out_set: assert property (
    WR && hit(ADDR, `PIC_OUT_SET_OFF) |=>
      ((st_q.odsr & $past(wv)) == $past(wv)))
    else $error("output data not set");

  a_filt_store: assert property (
    WR && hit(ADDR, `PIC_FLT_EN_OFF) |=>
      ((st_q.filt & $past(wv)) == $past(wv)))
    else $error("filter enable not stored");

  a_mask_clear: assert property (
    WR && hit(ADDR, `PIC_IRQ_DIS_OFF) |=>
      ((st_q.imr & $past(wv)) == 32'h00000000))
    else $error("interrupt mask not cleared");

  a_od_store: assert property (
    WR && hit(ADDR, `PIC_OD_EN_OFF) |=>
      ((st_q.md & $past(wv)) == $past(wv)))
    else $error("open drain enable not stored");

  a_owned_drive: assert property (
    1'b1 |=> ((PIN_OE & $past(st_q.own) & ~$past(st_q.dir))
      == 32'h00000000))
    else $error("owned input line driven");

  a_undef_zero: assert property (
    ((RDATA | PIN_OE | st_q.own) & ~LINE_MASK) == 32'h00000000)
    else $error("undefined line bits nonzero");

endmodule : pic_ctrl

// ### testbench/pic_pins.sv
// Far side of the pins: external drivers plus a pull-up.
// Assumes the bench keeps ext_oe low where the controller drives.
`timescale 1ns/1ps
module pic_pins (
  // Controller drive
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  // External drivers
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_oe,
  // Resolved level
  output logic      [31:0] pin_in
);
  // Released lines float up, so open drain reads high when not pulling
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                | (~pin_oe & ~ext_oe);
endmodule : pic_pins

// ### testbench/parallel_io_controller_bench.sv
// Self-checking bench for the second-port variant of pic_ctrl.
// Assumes pic_pins models the board; peripheral lines driven here.
`timescale 1ns/1ps
`include "pic_map.svh"
module parallel_io_controller_bench;
  import pic_pkg::*;
  localparam pic_word_t LM = `PIC_LINES_B;
  localparam pic_word_t SM = `PIC_SHARED_B;
  logic      clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, irq;
  logic [7:0] addr = 8'h00;
  pic_word_t wdata = '0, per_out = '0, per_oe = '0, ext_val = '0;
  pic_word_t ext_oe = '0, rdata, pin_in, pin_out, pin_oe, per_in;
  pic_word_t own, dir, odsr, md, r;
  int        err_count = 0, check_count = 0;
  always #50 clk = ~clk;
  pic_ctrl #(.LINE_MASK(LM), .SHARED_MASK(SM)) pic_ctrl_i (.CLK(clk),
    .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(we), .RD(re),
    .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PER_OUT(per_out), .PER_OE(per_oe), .PER_IN(per_in), .IRQ(irq));
  pic_pins pic_pins_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input pic_word_t g, input pic_word_t e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic reg_write(input logic [7:0] a, input pic_word_t d);
    @(posedge clk);
    {we, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    we <= 1'b0;
  endtask : reg_write
  task automatic chk_reg(input logic [7:0] a, input pic_word_t e);
    @(posedge clk);
    {re, addr} <= {1'b1, a};
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask : chk_reg
  // Clearing read whose value depends on earlier random traffic
  task automatic rd_clear(input logic [7:0] a);
    @(posedge clk);
    {re, addr} <= {1'b1, a};
    @(posedge clk);
    re <= 1'b0;
  endtask : rd_clear
  // Peripheral drive applies where it owns; open drain never drives high
  function automatic pic_word_t exp_oe();
    pic_word_t v;
    v = (own & odsr) | (~own & per_out);
    return ((own & dir) | (~own & per_oe)) & ~(md & v) & LM;
  endfunction : exp_oe
  function automatic pic_word_t exp_lvl();
    pic_word_t oe, v;
    oe = exp_oe();
    v = (own & odsr) | (~own & per_out);
    return LM & ((oe & v) | (~oe & ~ext_oe) | (~oe & ext_oe & ext_val));
  endfunction : exp_lvl
  initial begin
    #2_000_000;
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(22));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    {own, dir, odsr, md} = {LM, 96'h0};
    chk_reg(`PIC_OWN_STAT_OFF, LM);
    chk_reg(`PIC_DIR_STAT_OFF, '0);
    chk_reg(8'h0c, '0);
    chk_reg(`PIC_CHG_STAT_OFF, LM);
    chk_reg(`PIC_CHG_STAT_OFF, '0);
    for (int n = 0; n < 6; n++) begin
      r = $urandom();
      if (n == 3) reg_write(`PIC_OWN_EN_OFF, r);
      else reg_write(`PIC_OWN_DIS_OFF, r);
      own = (n == 3) ? own | (r & LM) : own & ~(r & SM);
      r = $urandom();
      reg_write(`PIC_DIR_EN_OFF, r);
      dir |= r & LM;
      r = $urandom();
      reg_write(`PIC_DIR_DIS_OFF, r);
      dir &= ~(r & LM);
      r = $urandom();
      reg_write(`PIC_OUT_SET_OFF, r);
      odsr |= r & LM;
      r = $urandom();
      reg_write(`PIC_OUT_CLR_OFF, r);
      odsr &= ~(r & LM);
      r = $urandom();
      reg_write((n % 2) ? `PIC_OD_EN_OFF : `PIC_OD_DIS_OFF, r);
      md = (n % 2) ? md | (r & LM) : md & ~(r & LM);
      per_out <= $urandom();
      per_oe <= $urandom();
      repeat (6) @(posedge clk);
      chk(pin_oe, exp_oe());
      chk(per_in, ~own & exp_lvl());
      chk_reg(`PIC_OWN_STAT_OFF, own);
      chk_reg(`PIC_DIR_STAT_OFF, dir);
      chk_reg(`PIC_OUT_STAT_OFF, odsr);
      chk_reg(`PIC_OD_STAT_OFF, md);
      chk_reg(`PIC_PIN_LVL_OFF, exp_lvl());
    end
    // Line 4 as an owned input, driven by the board's external driver
    reg_write(`PIC_OWN_EN_OFF, 32'h10);
    reg_write(`PIC_DIR_DIS_OFF, 32'h10);
    reg_write(`PIC_IRQ_EN_OFF, 32'h10);
    chk_reg(`PIC_IRQ_MASK_OFF, 32'h10);
    {ext_oe, ext_val} <= {32'h10, 32'h10};
    repeat (6) @(posedge clk);
    rd_clear(`PIC_CHG_STAT_OFF);
    chk_reg(`PIC_CHG_STAT_OFF, {31'h0, 1'b0});
    ext_val <= '0;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    chk_reg(`PIC_CHG_STAT_OFF, 32'h10);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    reg_write(`PIC_IRQ_DIS_OFF, 32'h10);
    chk_reg(`PIC_IRQ_MASK_OFF, '0);
    ext_val <= 32'h10;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    chk_reg(`PIC_CHG_STAT_OFF, 32'h10);
    for (int f = 1; f >= 0; f--) begin
      reg_write(f ? `PIC_FLT_EN_OFF : `PIC_FLT_DIS_OFF, 32'h10);
      chk_reg(`PIC_FLT_STAT_OFF, f ? 32'h10 : 32'h0);
      @(posedge clk);
      ext_val <= '0;
      @(posedge clk);
      ext_val <= 32'h10;
      repeat (6) @(posedge clk);
      chk_reg(`PIC_CHG_STAT_OFF, f ? 32'h0 : 32'h10);
    end
    print_verdict();
  end
endmodule : parallel_io_controller_bench
